// [inc/nvm_port_pkg.sv]
// constants and types for the parallel nonvolatile programming port
// How it works
// R01: eeprom write bytes gather in a page buffer, committed together
// R02: programmer loads write-eeprom command, high address, then low/data/latch
// R03: program pulse with byte select 00 commits eeprom page, busy low
// R04: programmer loads read-flash command then extended, high, low address
// R05: flash read drives low byte on byte_sel_lsb 0, high byte on 1
// R06: eeprom read drives addressed byte with output enable and lsb low
// R07: data bus released whenever output_enable_n is high
// R08: fuse write command then data byte; zero programs, one erases
// R09: byte select 00/01/10 picks low, high or extended fuse byte
// R10: programmer returns byte select to 00 after high or extended fuse
// R11: fuse and lock writes start on program pulse; wait for ready
// R12: lock write command then data byte; zero programs a lock bit
// R13: in lock mode 3 boot lock bits cannot be programmed
// R14: lock bits are cleared only by chip erase
// R15: fuse/lock read: 00 low, 11 high, 10 extended, 01 lock byte
// R16: signature read: low address 0 to 2 picks signature byte
// R17: signature command, address 0, lsb high drives calibration byte
// R18: ready_busy_n goes low within 1 us of program pulse fall
// R19: writes keep busy for a self-timed 3.7 to 4.5 ms
// R20: chip erase keeps busy for 7.5 to 9 ms
// R21: load strobe action: 00 address, 01 data, 10 command, 11 idle
// R22: address byte select: 00 low, 01 high, 10 extended
// R23: command and address are retained across accesses
// R24: no-operation command resets write signals and ends page load
// R25: program pulses are ignored while busy
`default_nettype none
package nvm_port_pkg;
  localparam logic [7:0] cmd_erase = 8'h80;
  localparam logic [7:0] cmd_wr_fuse = 8'h40;
  localparam logic [7:0] cmd_wr_lock = 8'h20;
  localparam logic [7:0] cmd_wr_flash = 8'h10;
  localparam logic [7:0] cmd_wr_eeprom = 8'h11;
  localparam logic [7:0] cmd_rd_sig = 8'h08;
  localparam logic [7:0] cmd_rd_fuse = 8'h04;
  localparam logic [7:0] cmd_rd_flash = 8'h02;
  localparam logic [7:0] cmd_rd_eeprom = 8'h03;
  localparam logic [7:0] cmd_nop = 8'h00;
  localparam logic [1:0] act_addr = 2'h0;
  localparam logic [1:0] act_data = 2'h1;
  localparam logic [1:0] act_cmd = 2'h2;
  localparam int ee_aw = 10;
  localparam int ee_page = 8;
  localparam int ee_pw = 3;
  localparam int fl_aw = 14;
  localparam int clk_mhz = 200;
  localparam int busy_lat_ns = 1000;
  // self-timed durations in microseconds, chosen inside the allowed window
  localparam int write_done_us = 4000;
  localparam int erase_done_us = 8000;
  localparam int write_done_cyc = write_done_us * clk_mhz;
  localparam int erase_done_cyc = erase_done_us * clk_mhz;
  localparam int busy_lat_cyc = busy_lat_ns * clk_mhz / 1000;
  localparam logic [7:0] fuse_lo_rst = 8'hff;
  localparam logic [7:0] fuse_hi_rst = 8'hff;
  localparam logic [7:0] fuse_ext_rst = 8'hff;
  localparam logic [7:0] lock_rst = 8'hff;
  localparam int lock_one_bit = 0;
  localparam int lock_two_bit = 1;
  localparam logic [7:0] boot_lock_mask = 8'h3c;
  typedef enum logic [1:0] {st_idle, st_busy} phase_t;
endpackage : nvm_port_pkg
`default_nettype wire

// [core/busy_timer.sv]
// self-timed busy countdown
`default_nettype none
module busy_timer #(
  parameter int write_cycles = 800000,
  parameter int erase_cycles = 1600000
) (
  input wire logic clk,
  input wire logic nrst,
  input wire logic start,
  input wire logic is_erase,
  output logic done,
  output logic running
);
  logic [21:0] cnt_r;
  logic [21:0] cnt_nxt;
  logic [21:0] load_val;
  assign load_val = is_erase ? 22'(erase_cycles - 1) : 22'(write_cycles - 1);
  assign cnt_nxt = (start && !running) ? load_val :
                   (running && cnt_r != 22'h0) ? cnt_r - 22'h1 : cnt_r;
  always_ff @(posedge clk) begin
    if (!nrst) begin
      cnt_r <= 22'h0;
      running <= 1'b0;
      done <= 1'b0;
    end else begin
      cnt_r <= cnt_nxt;
      done <= running && cnt_r == 22'h0;
      if (start && !running) begin
        running <= 1'b1;
      end else if (running && cnt_r == 22'h0) begin
        running <= 1'b0;
      end
    end
  end
endmodule : busy_timer
`default_nettype wire

// [core/nvm_port.sv]
// device side of the parallel programming port
`default_nettype none
module nvm_port
  import nvm_port_pkg::*;
#(
  parameter int write_cycles = write_done_cyc,
  parameter int erase_cycles = erase_done_cyc,
  parameter logic [7:0] sig0 = 8'h5a, // arbitrary
  parameter logic [7:0] sig1 = 8'h01, // arbitrary
  parameter logic [7:0] sig2 = 8'h02, // arbitrary
  parameter logic [7:0] calib = 8'h80
) (
  input wire logic clk,
  input wire logic nrst,
  input wire logic load_strobe,
  input wire logic buffer_latch_strobe,
  input wire logic program_pulse_n,
  input wire logic output_enable_n,
  input wire logic action_sel_hi,
  input wire logic action_sel_lo,
  input wire logic byte_sel_lsb,
  input wire logic byte_sel_msb,
  input wire logic [7:0] data_in,
  output logic [7:0] data_out,
  output logic data_oe,
  output logic ready_busy_n,
  output logic [7:0] fuse_lo,
  output logic [7:0] fuse_hi,
  output logic [7:0] fuse_ext,
  output logic [7:0] lock_bits
);
  // previous pin samples for edge detection
  logic load_d_r;
  logic latch_d_r;
  logic prog_d_r;
  logic [7:0] cmd_r;
  logic [7:0] addr_lo_r;
  logic [7:0] addr_hi_r;
  logic [7:0] addr_ext_r;
  logic [7:0] data_lo_r;
  logic [7:0] data_hi_r;
  logic [7:0] ee_mem_r [1<<ee_aw];
  logic [15:0] fl_mem_r [1<<fl_aw];
  logic [7:0] ee_buf_r [ee_page];
  logic [ee_page-1:0] ee_bv_r;
  logic [15:0] fl_buf_r;
  logic fl_bv_r;
  phase_t phase_r;
  logic [1:0] pend_r;
  logic [ee_aw-1:0] ee_pg_r;
  logic [fl_aw-1:0] fl_pg_r;
  logic [7:0] pend_data_r;
  logic [1:0] pend_sel_r;
  logic t_done;

  wire [1:0] act = {action_sel_hi, action_sel_lo};
  wire [1:0] bsel = {byte_sel_msb, byte_sel_lsb};
  wire load_rise = load_strobe && !load_d_r;
  wire latch_rise = buffer_latch_strobe && !latch_d_r;
  wire prog_fall = !program_pulse_n && prog_d_r;
  wire [ee_aw-1:0] ee_addr = ee_aw'({addr_hi_r, addr_lo_r});
  wire [fl_aw-1:0] fl_addr = fl_aw'({addr_ext_r, addr_hi_r, addr_lo_r});
  wire lock_mode3 = !lock_bits[lock_one_bit] && !lock_bits[lock_two_bit];
  wire idle = phase_r == st_idle;
  // program pulse accepted only while idle [R25]
  wire go = prog_fall && idle && ready_busy_n;
  wire is_wr = cmd_r == cmd_wr_eeprom || cmd_r == cmd_wr_flash ||
               cmd_r == cmd_wr_fuse || cmd_r == cmd_wr_lock;
  wire erase_cmd = cmd_r == cmd_erase;
  wire start = go && (is_wr || erase_cmd);

  // read data selection
  logic [7:0] rd_byte;
  logic rd_valid;
  always_comb begin
    rd_byte = 8'h00;
    rd_valid = 1'b1;
    case (cmd_r)
      cmd_rd_flash: rd_byte = byte_sel_lsb ? fl_mem_r[fl_addr][15:8]
                                           : fl_mem_r[fl_addr][7:0]; // [R05]
      cmd_rd_eeprom: begin
        rd_byte = ee_mem_r[ee_addr]; // [R06]
        rd_valid = !byte_sel_lsb;
      end
      cmd_rd_fuse: begin
        case (bsel) // [R15]
          2'h0: rd_byte = fuse_lo;
          2'h3: rd_byte = fuse_hi;
          2'h2: rd_byte = fuse_ext;
          default: rd_byte = lock_bits;
        endcase
      end
      cmd_rd_sig: begin
        if (byte_sel_lsb) begin
          rd_byte = calib; // [R17]
          rd_valid = addr_lo_r == 8'h00;
        end else begin
          case (addr_lo_r) // [R16]
            8'h00: rd_byte = sig0;
            8'h01: rd_byte = sig1;
            8'h02: rd_byte = sig2;
            default: rd_valid = 1'b0;
          endcase
        end
      end
      default: rd_valid = 1'b0;
    endcase
  end

  busy_timer #(
    .write_cycles(write_cycles),
    .erase_cycles(erase_cycles)
  ) u_timer (
    .clk(clk),
    .nrst(nrst),
    .start(start), // [R19] [R20]
    .is_erase(erase_cmd),
    .done(t_done),
    .running()
  );

  always_ff @(posedge clk) begin
    if (!nrst) begin
      load_d_r <= 1'b0;
      latch_d_r <= 1'b0;
      prog_d_r <= 1'b1;
      data_out <= 8'h00;
      data_oe <= 1'b0;
    end else begin
      load_d_r <= load_strobe;
      latch_d_r <= buffer_latch_strobe;
      prog_d_r <= program_pulse_n;
      data_out <= rd_byte;
      data_oe <= !output_enable_n && rd_valid; // [R07]
    end
  end

  // command, address and data loading [R21] [R23]
  always_ff @(posedge clk) begin
    if (!nrst) begin
      cmd_r <= cmd_nop;
      addr_lo_r <= 8'h00;
      addr_hi_r <= 8'h00;
      addr_ext_r <= 8'h00;
      data_lo_r <= 8'h00;
      data_hi_r <= 8'h00;
    end else if (load_rise) begin
      case (act)
        act_addr: begin
          case (bsel) // [R22]
            2'h0: addr_lo_r <= data_in;
            2'h1: addr_hi_r <= data_in;
            2'h2: addr_ext_r <= data_in;
            default: ;
          endcase
        end
        act_data: begin
          if (byte_sel_lsb) begin
            data_hi_r <= data_in;
          end else begin
            data_lo_r <= data_in;
          end
        end
        act_cmd: cmd_r <= data_in;
        default: ;
      endcase
    end
  end

  // page buffers, commit sequencing and nonvolatile arrays
  wire nop_load = load_rise && act == act_cmd && data_in == cmd_nop;
  wire nop_clear = nop_load && idle;
  wire [ee_pw-1:0] ee_idx = ee_addr[ee_pw-1:0];
  wire ee_latch = latch_rise && idle && cmd_r == cmd_wr_eeprom;
  wire fl_latch = latch_rise && idle && cmd_r == cmd_wr_flash;

  wire commit = phase_r == st_busy && t_done;
  wire wipe = commit && erase_cmd;
  wire settle = commit && !erase_cmd;
  wire ee_commit = settle && pend_r == 2'h0 && pend_sel_r == 2'h0;
  wire fuse_commit = settle && pend_r == 2'h1;
  wire lock_commit = settle && pend_r == 2'h2;
  wire fl_commit = settle && pend_r == 2'h3;
  wire fl_store = fl_commit && cmd_r == cmd_wr_flash && fl_bv_r;
  wire [1:0] pend_code = cmd_r == cmd_wr_eeprom ? 2'h0 :
                         cmd_r == cmd_wr_fuse ? 2'h1 :
                         cmd_r == cmd_wr_lock ? 2'h2 : 2'h3;
  // in lock mode 3 the boot lock bits keep their value
  wire [7:0] lock_keep = lock_mode3 ? (pend_data_r | boot_lock_mask) // [R13]
                                    : pend_data_r;

  // busy phase: entered on an accepted pulse under a write or erase command, left when the timer ends
  always_ff @(posedge clk) begin
    if (!nrst) begin
      phase_r <= st_idle;
      ready_busy_n <= 1'b1;
    end else if (start) begin
      phase_r <= st_busy;
      ready_busy_n <= 1'b0; // [R18] [R03] [R11]
    end else if (commit) begin
      phase_r <= st_idle;
      ready_busy_n <= 1'b1;
    end
  end

  // operation parameters frozen at the pulse
  always_ff @(posedge clk) begin
    if (!nrst) begin
      pend_r <= 2'h0;
      pend_sel_r <= 2'h0;
      pend_data_r <= 8'h00;
      ee_pg_r <= '0;
      fl_pg_r <= '0;
    end else if (start) begin
      pend_r <= pend_code;
      pend_sel_r <= bsel;
      pend_data_r <= data_lo_r;
      ee_pg_r <= ee_addr;
      fl_pg_r <= fl_addr;
    end
  end

  // eeprom page valid bits
  always_ff @(posedge clk) begin
    if (!nrst) begin
      ee_bv_r <= '0;
    end else if (nop_clear) begin
      ee_bv_r <= '0; // [R24]
    end else if (ee_commit) begin
      ee_bv_r <= '0; // [R03]
    end else if (ee_latch) begin
      ee_bv_r[ee_idx] <= 1'b1;
    end
  end

  // one page buffer entry per byte of the page
  genvar gi;
  for (gi = 0; gi < ee_page; gi++) begin : g_ee
    always_ff @(posedge clk) begin
      if (nrst && ee_latch && ee_idx == ee_pw'(gi)) begin
        ee_buf_r[gi] <= data_lo_r; // [R01]
      end
    end
  end

  // every latched byte of the page lands in the array in one commit
  always_ff @(posedge clk) begin
    if (nrst && ee_commit) begin
      for (int i = 0; i < ee_page; i++) begin
        if (ee_bv_r[i]) begin
          ee_mem_r[{ee_pg_r[ee_aw-1:ee_pw], ee_pw'(i)}] <= ee_buf_r[i];
        end
      end
    end
  end

  // flash word buffer
  always_ff @(posedge clk) begin
    if (!nrst) begin
      fl_bv_r <= 1'b0;
      fl_buf_r <= 16'h0000;
    end else if (nop_clear) begin
      fl_bv_r <= 1'b0; // [R24]
    end else if (fl_latch) begin
      fl_buf_r <= {data_hi_r, data_lo_r};
      fl_bv_r <= 1'b1;
    end else if (fl_commit) begin
      fl_bv_r <= 1'b0;
    end
  end

  always_ff @(posedge clk) begin
    if (nrst && fl_store) begin
      fl_mem_r[fl_pg_r] <= fl_buf_r;
    end
  end

  // fuse bytes: the byte select held at the pulse picks the target
  always_ff @(posedge clk) begin
    if (!nrst) begin
      fuse_lo <= fuse_lo_rst;
      fuse_hi <= fuse_hi_rst;
      fuse_ext <= fuse_ext_rst;
    end else if (fuse_commit) begin
      case (pend_sel_r) // [R08] [R09]
        2'h0: fuse_lo <= pend_data_r;
        2'h1: fuse_hi <= pend_data_r;
        2'h2: fuse_ext <= pend_data_r;
        default: ;
      endcase
    end
  end

  // lock bits only ever go to zero, except by chip erase
  always_ff @(posedge clk) begin
    if (!nrst) begin
      lock_bits <= lock_rst;
    end else if (wipe) begin
      lock_bits <= lock_rst; // [R14]
    end else if (lock_commit) begin
      lock_bits <= lock_bits & lock_keep; // [R12] [R14]
    end
  end
endmodule : nvm_port
`default_nettype wire

// [test/nvm_port_assertions.sv]
// checker on the programming port pins
`default_nettype none
module nvm_port_chk
  import nvm_port_pkg::*;
#(parameter int write_cycles = 20, parameter int erase_cycles = 40) (
  input wire logic clk,
  input wire logic nrst,
  input wire logic program_pulse_n,
  input wire logic output_enable_n,
  input wire logic data_oe,
  input wire logic ready_busy_n,
  input wire logic [7:0] fuse_lo,
  input wire logic [7:0] fuse_hi,
  input wire logic [7:0] fuse_ext,
  input wire logic [7:0] lock_bits
);
  timeunit 1ns;
  timeprecision 100ps;
  int cnt_r;
  logic [31:0] nv;
  logic mode3;
  logic wr_end;
  assign nv = {fuse_lo, fuse_hi, fuse_ext, lock_bits};
  assign mode3 = !lock_bits[lock_one_bit] && !lock_bits[lock_two_bit];
  // busy lasts one cycle beyond the count: the registered done cycle
  assign wr_end = ready_busy_n && cnt_r == write_cycles + 1;
  // cycles spent busy so far
  always_ff @(posedge clk) begin
    if (!nrst || ready_busy_n) cnt_r <= 0;
    else cnt_r <= cnt_r + 1;
  end
  default clocking @(posedge clk);
  endclocking
  default disable iff (!nrst);
  chk_oe_release: assert property (output_enable_n |=> !data_oe)
    else $error("bus driven after oe high");
  chk_oe_cause: assert property (data_oe |-> $past(!output_enable_n))
    else $error("bus driven without oe");
  chk_busy_cause: assert property ($fell(ready_busy_n) |-> !program_pulse_n)
    else $error("busy without program pulse");
  chk_busy_span: assert property ($rose(ready_busy_n) |->
    cnt_r == write_cycles + 1 || cnt_r == erase_cycles + 1)
    else $error("busy length wrong");
  chk_nv_commit: assert property ($changed(nv) |-> $rose(ready_busy_n))
    else $error("fuse or lock changed outside commit");
  chk_lock_mono: assert property ($rose(ready_busy_n) && wr_end |->
    (lock_bits & ~$past(lock_bits)) == 8'h00)
    else $error("lock bit cleared by a write");
  chk_boot_lock: assert property ($rose(ready_busy_n) && wr_end &&
    $past(mode3) |-> ((lock_bits ^ $past(lock_bits)) & boot_lock_mask) == 0)
    else $error("boot lock changed in mode 3");
  chk_fuse_one: assert property ($rose(ready_busy_n) |-> $onehot0({
    fuse_lo != $past(fuse_lo), fuse_hi != $past(fuse_hi),
    fuse_ext != $past(fuse_ext)})) else $error("two fuse bytes written");
  cover property ($rose(ready_busy_n) && cnt_r == erase_cycles + 1);
  cover property ($rose(ready_busy_n) && wr_end);
  cover property (data_oe);
endmodule : nvm_port_chk
bind nvm_port nvm_port_chk #(
  .write_cycles(write_cycles),
  .erase_cycles(erase_cycles)
) u_chk (
  .clk(clk),
  .nrst(nrst),
  .program_pulse_n(program_pulse_n),
  .output_enable_n(output_enable_n),
  .data_oe(data_oe),
  .ready_busy_n(ready_busy_n),
  .fuse_lo(fuse_lo),
  .fuse_hi(fuse_hi),
  .fuse_ext(fuse_ext),
  .lock_bits(lock_bits)
);
`default_nettype wire

// [test/nvm_prog.sv]
// programmer model driving the port strobes and bus
`default_nettype none
module nvm_prog (
  input wire logic clk,
  input wire logic [7:0] data_out,
  input wire logic data_oe,
  input wire logic ready_busy_n,
  output logic load_strobe,
  output logic buffer_latch_strobe,
  output logic program_pulse_n,
  output logic output_enable_n,
  output logic action_sel_hi,
  output logic action_sel_lo,
  output logic byte_sel_lsb,
  output logic byte_sel_msb,
  output logic [7:0] data_in
);
  timeunit 1ns;
  timeprecision 100ps;
  initial begin
    {load_strobe, buffer_latch_strobe} = 2'h0;
    {action_sel_hi, action_sel_lo} = 2'h3;
    {program_pulse_n, output_enable_n} = 2'h3;
    {byte_sel_msb, byte_sel_lsb} = 2'h0;
    data_in = 8'h00;
  end
  task automatic step(input int n);
    repeat (n) @(posedge clk);
    #1;
  endtask : step
  // strobes stay two cycles in each level so every edge is seen
  task automatic ld(input logic [1:0] a, input logic [1:0] b,
                    input logic [7:0] v);
    {action_sel_hi, action_sel_lo} = a;
    {byte_sel_msb, byte_sel_lsb} = b;
    data_in = v;
    step(1);
    load_strobe = 1'b1;
    step(2);
    load_strobe = 1'b0;
    step(2);
  endtask : ld
  task automatic latch();
    buffer_latch_strobe = 1'b1;
    step(2);
    buffer_latch_strobe = 1'b0;
    step(2);
  endtask : latch
  // a second pulse while busy must be ignored
  task automatic pulse(input logic [1:0] b, output int lat);
    int n;
    {byte_sel_msb, byte_sel_lsb} = b;
    step(1);
    program_pulse_n = 1'b0;
    lat = 0;
    while (ready_busy_n !== 1'b0 && lat < 250) begin
      step(1);
      lat++;
    end
    step(2);
    program_pulse_n = 1'b1;
    step(2);
    program_pulse_n = 1'b0;
    step(2);
    program_pulse_n = 1'b1;
    n = 0;
    while (ready_busy_n !== 1'b1 && n < 1000) begin
      step(1);
      n++;
    end
    {byte_sel_msb, byte_sel_lsb} = 2'h0;
    step(1);
  endtask : pulse
  task automatic rd(input logic [1:0] b, output logic [7:0] v,
                    output logic oe);
    {byte_sel_msb, byte_sel_lsb} = b;
    data_in = ~data_in;
    output_enable_n = 1'b0;
    step(3);
    v = data_out;
    oe = data_oe;
    output_enable_n = 1'b1;
    step(2);
  endtask : rd
endmodule : nvm_prog
`default_nettype wire

// [test/tb_top.sv]
// self-checking bench for the programming port
`default_nettype none
module tb_top;
  timeunit 1ns;
  timeprecision 100ps;
  import nvm_port_pkg::*;
  logic clk = 1'b0;
  logic nrst = 1'b0;
  logic load_strobe, buffer_latch_strobe, program_pulse_n, output_enable_n;
  logic action_sel_hi, action_sel_lo, byte_sel_lsb, byte_sel_msb, data_oe;
  logic ready_busy_n;
  logic [7:0] data_in, data_out, fuse_lo, fuse_hi, fuse_ext, lock_bits;
  logic [7:0] v;
  logic oe;
  int lat;
  int errors = 0;
  int total_checks = 0;
  // arbitrary signature values, calibration byte left at its default
  logic [7:0] sg [4] = '{8'h3c, 8'h91, 8'h47, 8'h80};
  always #2.5 clk = ~clk;
  nvm_port #(.write_cycles(20), .erase_cycles(40), .sig0(8'h3c),
    .sig1(8'h91), .sig2(8'h47)) u_dut (
    .clk(clk), .nrst(nrst), .load_strobe(load_strobe),
    .buffer_latch_strobe(buffer_latch_strobe),
    .program_pulse_n(program_pulse_n), .output_enable_n(output_enable_n),
    .action_sel_hi(action_sel_hi), .action_sel_lo(action_sel_lo),
    .byte_sel_lsb(byte_sel_lsb), .byte_sel_msb(byte_sel_msb),
    .data_in(data_in), .data_out(data_out), .data_oe(data_oe),
    .ready_busy_n(ready_busy_n), .fuse_lo(fuse_lo), .fuse_hi(fuse_hi),
    .fuse_ext(fuse_ext), .lock_bits(lock_bits)
  );
  nvm_prog u_prog (
    .clk(clk), .data_out(data_out), .data_oe(data_oe),
    .ready_busy_n(ready_busy_n), .load_strobe(load_strobe),
    .buffer_latch_strobe(buffer_latch_strobe),
    .program_pulse_n(program_pulse_n), .output_enable_n(output_enable_n),
    .action_sel_hi(action_sel_hi), .action_sel_lo(action_sel_lo),
    .byte_sel_lsb(byte_sel_lsb), .byte_sel_msb(byte_sel_msb),
    .data_in(data_in)
  );
  task automatic chk8(input logic [7:0] g, input logic [7:0] e);
    total_checks++;
    if (g !== e) begin
      errors++;
      $display("BAD %0t got %h want %h", $time, g, e);
    end
  endtask : chk8
  task automatic chk1(input logic g, input logic e);
    chk8({7'h0, g}, {7'h0, e});
  endtask : chk1
  task automatic t_eeprom;
    u_prog.ld(act_cmd, 2'h0, cmd_wr_eeprom);
    u_prog.ld(act_addr, 2'h1, 8'h01);
    for (int i = 0; i < ee_page; i++) begin
      u_prog.ld(act_addr, 2'h0, 8'h08 + 8'(i));
      u_prog.ld(act_data, 2'h0, 8'ha0 + 8'(i));
      u_prog.latch();
    end
    u_prog.pulse(2'h0, lat);
    chk1(lat <= busy_lat_cyc, 1'b1);
    u_prog.ld(act_cmd, 2'h0, cmd_rd_eeprom);
    for (int i = 0; i < ee_page; i++) begin
      u_prog.ld(act_addr, 2'h0, 8'h08 + 8'(i));
      u_prog.rd(2'h0, v, oe);
      chk8(v, 8'ha0 + 8'(i));
    end
    chk1(oe, 1'b1);
    u_prog.rd(2'h1, v, oe);
    chk1(oe, 1'b0);
    chk1(data_oe, 1'b0);
    // a latched byte dropped by the no-operation command is never written
    u_prog.ld(act_cmd, 2'h0, cmd_wr_eeprom);
    u_prog.ld(act_addr, 2'h0, 8'h08);
    u_prog.ld(act_data, 2'h0, 8'h55);
    u_prog.latch();
    u_prog.ld(act_cmd, 2'h0, cmd_nop);
    u_prog.ld(act_cmd, 2'h0, cmd_wr_eeprom);
    u_prog.pulse(2'h0, lat);
    u_prog.ld(act_cmd, 2'h0, cmd_rd_eeprom);
    u_prog.rd(2'h0, v, oe);
    chk8(v, 8'ha0);
    $display("eeprom test end");
  endtask : t_eeprom
  task automatic t_flash;
    u_prog.ld(act_cmd, 2'h0, cmd_wr_flash);
    u_prog.ld(act_addr, 2'h1, 8'h00);
    u_prog.ld(act_addr, 2'h0, 8'h05);
    u_prog.ld(act_data, 2'h0, 8'h34);
    u_prog.ld(act_data, 2'h1, 8'h12);
    u_prog.latch();
    u_prog.pulse(2'h0, lat);
    u_prog.ld(act_cmd, 2'h0, cmd_rd_flash);
    u_prog.ld(act_addr, 2'h2, 8'h00);
    u_prog.ld(act_addr, 2'h1, 8'h00);
    u_prog.ld(act_addr, 2'h0, 8'h05);
    u_prog.rd(2'h0, v, oe);
    chk8(v, 8'h34);
    u_prog.rd(2'h1, v, oe);
    chk8(v, 8'h12);
    $display("flash test end");
  endtask : t_flash
  task automatic t_fuse;
    logic [7:0] fv [3] = '{8'h5e, 8'hd9, 8'hf3};
    logic [1:0] rs [3] = '{2'h0, 2'h3, 2'h2};
    u_prog.ld(act_cmd, 2'h0, cmd_wr_fuse);
    for (int k = 0; k < 3; k++) begin
      u_prog.ld(act_data, 2'h0, fv[k]);
      u_prog.pulse(2'(k), lat);
    end
    chk8(fuse_lo, 8'h5e);
    chk8(fuse_hi, 8'hd9);
    chk8(fuse_ext, 8'hf3);
    u_prog.ld(act_data, 2'h0, 8'hff);
    u_prog.pulse(2'h0, lat);
    fv[0] = 8'hff;
    u_prog.ld(act_cmd, 2'h0, cmd_rd_fuse);
    for (int k = 0; k < 3; k++) begin
      u_prog.rd(rs[k], v, oe);
      chk8(v, fv[k]);
    end
    $display("fuse test end");
  endtask : t_fuse
  task automatic t_lock;
    u_prog.ld(act_cmd, 2'h0, cmd_wr_lock);
    u_prog.ld(act_data, 2'h0, 8'hfc);
    u_prog.pulse(2'h0, lat);
    chk8(lock_bits, 8'hfc);
    u_prog.ld(act_data, 2'h0, 8'h03);
    u_prog.pulse(2'h0, lat);
    chk8(lock_bits, 8'h3c);
    u_prog.ld(act_cmd, 2'h0, cmd_rd_fuse);
    u_prog.rd(2'h1, v, oe);
    chk8(v, 8'h3c);
    u_prog.ld(act_cmd, 2'h0, cmd_erase);
    u_prog.pulse(2'h0, lat);
    chk8(lock_bits, 8'hff);
    u_prog.ld(act_cmd, 2'h0, cmd_wr_lock);
    u_prog.ld(act_data, 2'h0, 8'hc3);
    u_prog.pulse(2'h0, lat);
    chk8(lock_bits, 8'hc3);
    u_prog.ld(act_cmd, 2'h0, cmd_nop);
    u_prog.pulse(2'h0, lat);
    chk1(lat == 250, 1'b1);
    $display("lock test end");
  endtask : t_lock
  task automatic t_sig;
    u_prog.ld(act_cmd, 2'h0, cmd_rd_sig);
    for (int a = 0; a < 3; a++) begin
      u_prog.ld(act_addr, 2'h0, 8'(a));
      u_prog.rd(2'h0, v, oe);
      chk8(v, sg[a]);
    end
    u_prog.ld(act_addr, 2'h0, 8'h00);
    u_prog.rd(2'h1, v, oe);
    chk8(v, sg[3]);
    $display("signature test end");
  endtask : t_sig
  task automatic summarize;
    $display("checks %0d errors %0d", total_checks, errors);
    if (errors == 0 && total_checks > 0) $display("Finished cleanly");
    else $display("Finished with errors");
    $finish;
  endtask : summarize
  initial begin
    #200000;
    errors++;
    $display("BAD %0t watchdog expired", $time);
    summarize();
  end
  initial begin
    repeat (20) @(posedge clk);
    #1 nrst = 1'b1;
    t_eeprom();
    t_flash();
    t_fuse();
    t_lock();
    t_sig();
    summarize();
  end
endmodule : tb_top
`default_nettype wire
